// [core/stat_det_pkg.sv]
package stat_det_pkg;
   // clock and timing
   localparam int CLK_MHZ = 250;
   localparam int ODR_HZ = 200;
   localparam int ODR_CYC = CLK_MHZ * 1000000 / ODR_HZ;
   localparam int CHG_TIME_US = 1200;
   localparam int CHG_CYC = CHG_TIME_US * CLK_MHZ;
   localparam int SLEEP_UNIT = 512;
   localparam int SMP_W = 16;
   localparam int THS_SHIFT = 9;
   // register indices, byte address is four times the index
   localparam logic [7:0] IX_INT_CTRL = 8'h22;
   localparam logic [7:0] IX_ROUTE = 8'h23;
   localparam logic [7:0] IX_WAKE_THS = 8'h34;
   localparam logic [7:0] IX_WAKE_DURATION = 8'h35;
   localparam logic [7:0] IX_INT_SRC = 8'h3B;
   localparam logic [7:0] IX_OFS_CTRL = 8'h3F;
   localparam logic [7:0] IX_IRQ_STAT = 8'h40;
   localparam logic [7:0] IX_IRQ_MASK = 8'h41;
   // fields
   localparam int LATCH_BIT = 2;
   localparam int SLEEP_EN_BIT = 6;
   localparam int THS_MSB = 5;
   localparam int STAT_BIT = 4;
   localparam int WDUR_MSB = 6;
   localparam int WDUR_LSB = 5;
   localparam int SDUR_MSB = 3;
   localparam int SRC_SEL_BIT = 0;
   localparam int RT_WAKE0 = 0;
   localparam int RT_SLEEP1 = 1;
   localparam int RT_CHG1 = 2;
   localparam int EV_WAKE = 0;
   localparam int EV_SLEEP = 1;
   localparam int EV_CHG = 2;
   localparam int EV_W = 3;
   localparam logic [7:0] REG_RST = 8'h00;
endpackage : stat_det_pkg

// [core/stationary_activity_detector.sv]
`timescale 1ns/1ns
module stationary_activity_detector #(
   parameter int ODR_DIV = stat_det_pkg::ODR_CYC,
   parameter int CHG_CYCLES = stat_det_pkg::CHG_CYC,
   parameter int SLEEP_STEP = stat_det_pkg::SLEEP_UNIT
) (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // filtered samples
   input wire logic [15:0] hp_x,
   input wire logic [15:0] hp_y,
   input wire logic [15:0] hp_z,
   // offset-corrected samples
   input wire logic [15:0] ofs_x,
   input wire logic [15:0] ofs_y,
   input wire logic [15:0] ofs_z,
   // pins and interrupt
   output logic int0_pin,
   output logic int1_pin,
   output logic irq
);
   localparam int EW = stat_det_pkg::EV_W;
   logic [7:0] int_ctrl_r, route_r, wake_ths_r, wake_duration_r, ofs_ctrl_r;
   logic [EW-1:0] irq_stat_r, irq_mask_r, ev;
   logic [31:0] prdata_r, odr_cnt_r, chg_cnt_r, rdat;
   logic [15:0] sleep_cnt_r, thr, sleep_tgt;
   logic [15:0] mag [3];
   logic [15:0] smp [3];
   logic [2:0] wake_cnt_r;
   logic pready_r, pslverr_r, tick, asleep_r, wake_flag_r, chg_flag_r;
   logic int0_r, int1_r, irq_r, det_en, latch, any_above, all_below;
   logic wake_hit, sleep_hit, acc, wr, rd, src_rd, stat_rd, hit;
   logic [7:0] ix;
   assign acc = psel && penable && pready_r;
   assign wr = acc && pwrite;
   assign rd = acc && !pwrite;
   assign ix = paddr[9:2];
   assign src_rd = rd && hit && ix == stat_det_pkg::IX_INT_SRC;
   assign stat_rd = rd && hit && ix == stat_det_pkg::IX_IRQ_STAT;
   assign det_en = wake_ths_r[stat_det_pkg::SLEEP_EN_BIT]
      && wake_duration_r[stat_det_pkg::STAT_BIT];
   assign latch = int_ctrl_r[stat_det_pkg::LATCH_BIT];
   assign thr = 16'(wake_ths_r[stat_det_pkg::THS_MSB:0])
      << stat_det_pkg::THS_SHIFT;
   assign sleep_tgt = 16'(32'(wake_duration_r[stat_det_pkg::SDUR_MSB:0])
      * SLEEP_STEP);

   // sample source and magnitude
   always_comb
   begin
      smp[0] = ofs_ctrl_r[stat_det_pkg::SRC_SEL_BIT] ? ofs_x : hp_x;
      smp[1] = ofs_ctrl_r[stat_det_pkg::SRC_SEL_BIT] ? ofs_y : hp_y;
      smp[2] = ofs_ctrl_r[stat_det_pkg::SRC_SEL_BIT] ? ofs_z : hp_z;
      any_above = 1'b0;
      all_below = 1'b1;
      for (int i = 0; i < 3; i++)
      begin
         mag[i] = smp[i][15] ? 16'(-smp[i]) : smp[i];
         if (mag[i] > thr)
         begin
            any_above = 1'b1;
            all_below = 1'b0;
         end
      end
   end

   // wake fires after the duration in sample periods
   assign wake_hit = tick && any_above
      && wake_cnt_r == 3'(wake_duration_r[stat_det_pkg::WDUR_MSB:
      stat_det_pkg::WDUR_LSB]);
   assign sleep_hit = tick && all_below && det_en && !asleep_r
      && sleep_cnt_r >= sleep_tgt;
   assign ev = {asleep_r != (det_en && (sleep_hit || (asleep_r
      && !wake_hit))), sleep_hit, wake_hit};

   // output data rate divider
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         odr_cnt_r <= 32'h00000000;
      else if (odr_cnt_r == 32'(ODR_DIV - 1))
         odr_cnt_r <= 32'h00000000;
      else
         odr_cnt_r <= odr_cnt_r + 32'h00000001;
   end
   assign tick = odr_cnt_r == 32'(ODR_DIV - 1);

   // wake duration counter
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         wake_cnt_r <= 3'h0;
      else if (tick && !any_above)
         wake_cnt_r <= 3'h0;
      else if (tick && wake_cnt_r != 3'h4)
         wake_cnt_r <= wake_cnt_r + 3'h1;
   end

   // sleep timing and state
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         sleep_cnt_r <= 16'h0000;
         asleep_r <= 1'b0;
      end
      else if (!det_en)
      begin
         sleep_cnt_r <= 16'h0000;
         asleep_r <= 1'b0;
      end
      else if (tick)
      begin
         if (!all_below)
            sleep_cnt_r <= 16'h0000;
         else if (sleep_cnt_r != 16'hFFFF)
            sleep_cnt_r <= sleep_cnt_r + 16'h0001;
         if (wake_hit)
            asleep_r <= 1'b0;
         else if (sleep_hit)
            asleep_r <= 1'b1;
      end
   end

   // wake flag: one sample period, or held under latch
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         wake_flag_r <= 1'b0;
      else if (wake_hit)
         wake_flag_r <= 1'b1;
      else if (latch ? src_rd && prdata_r[stat_det_pkg::EV_WAKE] : tick)
         wake_flag_r <= 1'b0;
   end

   // state change flag held for a fixed time
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         chg_cnt_r <= 32'h00000000;
      else if (ev[stat_det_pkg::EV_CHG])
         chg_cnt_r <= 32'(CHG_CYCLES);
      else if (chg_cnt_r != 32'h00000000)
         chg_cnt_r <= chg_cnt_r - 32'h00000001;
   end
   assign chg_flag_r = chg_cnt_r != 32'h00000000;

   // pins; no dedicated stationary pin exists
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         int0_r <= 1'b0;
         int1_r <= 1'b0;
         irq_r <= 1'b0;
      end
      else
      begin
         int0_r <= route_r[stat_det_pkg::RT_WAKE0] && wake_flag_r;
         int1_r <= (route_r[stat_det_pkg::RT_SLEEP1] && asleep_r)
            || (route_r[stat_det_pkg::RT_CHG1] && chg_flag_r);
         irq_r <= |(irq_stat_r & irq_mask_r);
      end
   end

   // sticky status, set wins; read clears only what it returned
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         irq_stat_r <= '0;
      else
         irq_stat_r <= (irq_stat_r & ~(stat_rd ? prdata_r[EW-1:0] : '0)) | ev;
   end

   // register writes
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         int_ctrl_r <= stat_det_pkg::REG_RST;
         route_r <= stat_det_pkg::REG_RST;
         wake_ths_r <= stat_det_pkg::REG_RST;
         wake_duration_r <= stat_det_pkg::REG_RST;
         ofs_ctrl_r <= stat_det_pkg::REG_RST;
         irq_mask_r <= '0;
      end
      else if (wr)
      begin
         unique case (ix)
            stat_det_pkg::IX_INT_CTRL: int_ctrl_r <= pwdata[7:0];
            stat_det_pkg::IX_ROUTE: route_r <= pwdata[7:0];
            stat_det_pkg::IX_WAKE_THS: wake_ths_r <= pwdata[7:0];
            stat_det_pkg::IX_WAKE_DURATION: wake_duration_r <= pwdata[7:0];
            stat_det_pkg::IX_OFS_CTRL: ofs_ctrl_r <= pwdata[7:0];
            stat_det_pkg::IX_IRQ_MASK: irq_mask_r <= pwdata[EW-1:0];
            default: ;
         endcase
      end
   end

   // read mux and decode
   always_comb
   begin
      hit = paddr[11:10] == 2'h0;
      rdat = 32'h00000000;
      unique case (ix)
         stat_det_pkg::IX_INT_CTRL: rdat[7:0] = int_ctrl_r;
         stat_det_pkg::IX_ROUTE: rdat[7:0] = route_r;
         stat_det_pkg::IX_WAKE_THS: rdat[7:0] = wake_ths_r;
         stat_det_pkg::IX_WAKE_DURATION: rdat[7:0] = wake_duration_r;
         stat_det_pkg::IX_OFS_CTRL: rdat[7:0] = ofs_ctrl_r;
         stat_det_pkg::IX_INT_SRC:
            rdat[EW-1:0] = {chg_flag_r, asleep_r, wake_flag_r};
         stat_det_pkg::IX_IRQ_STAT: rdat[EW-1:0] = irq_stat_r;
         stat_det_pkg::IX_IRQ_MASK: rdat[EW-1:0] = irq_mask_r;
         default: hit = 1'b0;
      endcase
   end

   // apb answer with one wait state
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pready_r <= 1'b0;
         pslverr_r <= 1'b0;
         prdata_r <= 32'h00000000;
      end
      else
      begin
         pready_r <= psel && penable && !pready_r;
         pslverr_r <= psel && penable && !pready_r && !hit;
         if (psel && penable && !pready_r)
            prdata_r <= (hit && !pwrite) ? rdat : 32'h00000000;
      end
   end

   assign prdata = prdata_r;
   assign pready = pready_r;
   assign pslverr = pslverr_r;
   assign int0_pin = int0_r;
   assign int1_pin = int1_r;
   assign irq = irq_r;
   // checks
   property p_det_off;
      @(posedge pclk) disable iff (!presetn)
      !det_en |=> !asleep_r;
   endproperty
   a_det_off: assert property (p_det_off)
      else $error("sleep state without detection enabled");
   property p_sleep_cause;
      @(posedge pclk) disable iff (!presetn)
      $rose(asleep_r) |-> $past(tick && all_below && det_en);
   endproperty
   a_sleep_cause: assert property (p_sleep_cause)
      else $error("sleep entered without quiet sample");
   property p_wake_exit;
      @(posedge pclk) disable iff (!presetn)
      asleep_r && wake_hit |=> !asleep_r && sleep_cnt_r == 16'h0000;
   endproperty
   a_wake_exit: assert property (p_wake_exit)
      else $error("wake did not end sleep state");
   property p_chg_len;
      @(posedge pclk) disable iff (!presetn)
      ev[stat_det_pkg::EV_CHG] |=> chg_cnt_r == 32'(CHG_CYCLES);
   endproperty
   a_chg_len: assert property (p_chg_len)
      else $error("state change hold time wrong");
   property p_int1;
      @(posedge pclk) disable iff (!presetn)
      route_r[stat_det_pkg::RT_SLEEP1] && asleep_r |=> int1_r;
   endproperty
   a_int1: assert property (p_int1)
      else $error("sleep state not on pin one");
   property p_int0;
      @(posedge pclk) disable iff (!presetn)
      wake_hit && route_r[stat_det_pkg::RT_WAKE0] ##1
      route_r[stat_det_pkg::RT_WAKE0] |=> int0_r;
   endproperty
   a_int0: assert property (p_int0)
      else $error("wake not on pin zero");
   property p_wake_pulse;
      @(posedge pclk) disable iff (!presetn)
      wake_flag_r && tick && !latch && !wake_hit |=> !wake_flag_r;
   endproperty
   a_wake_pulse: assert property (p_wake_pulse)
      else $error("wake pulse longer than one sample period");
   property p_wake_hold;
      @(posedge pclk) disable iff (!presetn)
      wake_flag_r && !tick && !src_rd |=> wake_flag_r;
   endproperty
   a_wake_hold: assert property (p_wake_hold)
      else $error("wake pulse shorter than one sample period");
   property p_wake_duration;
      @(posedge pclk) disable iff (!presetn)
      $rose(wake_flag_r) |-> $past(wake_cnt_r) == $past(3'(wake_duration_r[
      stat_det_pkg::WDUR_MSB:stat_det_pkg::WDUR_LSB]));
   endproperty
   a_wake_duration: assert property (p_wake_duration)
      else $error("wake before duration elapsed");
   property p_src;
      @(posedge pclk) disable iff (!presetn)
      ofs_ctrl_r[stat_det_pkg::SRC_SEL_BIT] && {ofs_x, ofs_y, ofs_z} == '0
      |-> !any_above;
   endproperty
   a_src: assert property (p_src)
      else $error("wrong sample source");
   c_sleep: cover property (@(posedge pclk) disable iff (!presetn)
      $rose(asleep_r));
   c_wake_exit: cover property (@(posedge pclk) disable iff (!presetn)
      $fell(asleep_r));
   c_irq: cover property (@(posedge pclk) disable iff (!presetn)
      $rose(irq_r));
endmodule : stationary_activity_detector

// [tb/host_monitor.sv]
`timescale 1ns/1ns
module host_monitor (
   // clock
   input wire logic pclk,
   // pins
   input wire logic int0_pin,
   input wire logic int1_pin,
   // measures
   output int int0_w,
   output int int1_w,
   output int int0_n,
   output logic stationary
);
   int c0;
   int c1;
   // host view: sleep pin up, wake pin quiet
   assign stationary = int1_pin & ~int0_pin;
   always_ff @(posedge pclk)
   begin
      c0 <= int0_pin ? c0 + 1 : 0;
      c1 <= int1_pin ? c1 + 1 : 0;
      if (!int0_pin && c0 > 0)
         int0_w <= c0;
      if (!int1_pin && c1 > 0)
         int1_w <= c1;
      if (int0_pin && c0 == 0)
         int0_n <= int0_n + 1;
   end
endmodule : host_monitor

// [tb/stationary_activity_detector_bench.sv]
`timescale 1ns/1ns
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin n_mismatch++; \
   $display("ERROR %0t got %0h want %0h", $time, a, b); end end
module stationary_activity_detector_bench;
   localparam int OUTPUT_DATA_RATE = 20;
   localparam int CHG = 50;
   localparam logic [15:0] BIG = 16'hF830;
   logic pclk = 1'b0, presetn = 1'b0;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata, rd_v;
   logic pready, pslverr, int0_pin, int1_pin, irq, er_v, stat;
   logic [15:0] hp_a = 16'h0000, hp_b = 16'h0000, ofs_a = 16'h0000;
   int n_mismatch = 0, num_checks = 0, cyc = 0, w0, w1, n0, k;

   stationary_activity_detector #(.ODR_DIV(OUTPUT_DATA_RATE), .CHG_CYCLES(CHG),
      .SLEEP_STEP(2)) u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .hp_x(hp_a),
      .hp_y(hp_b), .hp_z(hp_b), .ofs_x(ofs_a), .ofs_y(hp_b), .ofs_z(hp_b),
      .int0_pin(int0_pin), .int1_pin(int1_pin), .irq(irq));
   host_monitor u_mon (.pclk(pclk), .int0_pin(int0_pin), .int1_pin(int1_pin),
      .int0_w(w0), .int1_w(w1), .int0_n(n0), .stationary(stat));

   always #2 pclk = ~pclk;
   always @(posedge pclk)
   begin
      cyc++;
      if (cyc > 20000)
      begin
         n_mismatch++;
         report_and_stop();
      end
   end

   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : report_and_stop

   task automatic idle(input int n);
      repeat (n) @(posedge pclk);
   endtask : idle

   task automatic apb(input logic w, input logic [7:0] ix, input logic [7:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= {2'b00, ix, 2'b00};
      pwdata <= {24'h000000, d};
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd_v = prdata;
      er_v = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask : apb

   task automatic t_reset();
      logic [7:0] ix [5];
      ix = '{stat_det_pkg::IX_INT_CTRL, stat_det_pkg::IX_WAKE_THS,
         stat_det_pkg::IX_WAKE_DURATION, stat_det_pkg::IX_OFS_CTRL,
         stat_det_pkg::IX_IRQ_MASK};
      for (int j = 0; j < 5; j++)
      begin
         apb(1'b0, ix[j], 8'h00);
         `CHK(rd_v, 32'h00000000)
         `CHK(er_v, 1'b0)
      end
      apb(1'b1, 8'h10, 8'hFF);
      `CHK(er_v, 1'b1)
      apb(1'b0, 8'h10, 8'h00);
      `CHK(rd_v, 32'h00000000)
      `CHK(er_v, 1'b1)
      $display("test reset done");
   endtask : t_reset

   task automatic t_wake();
      apb(1'b1, stat_det_pkg::IX_ROUTE, 8'h01);
      apb(1'b1, stat_det_pkg::IX_WAKE_THS, 8'h01);
      apb(1'b1, stat_det_pkg::IX_IRQ_MASK, 8'h01);
      k = n0;
      hp_a <= BIG;
      idle(3 * OUTPUT_DATA_RATE);
      hp_a <= 16'h0000;
      idle(2 * OUTPUT_DATA_RATE);
      `CHK(n0, k + 1)
      `CHK(w0, OUTPUT_DATA_RATE)
      `CHK(irq, 1'b1)
      apb(1'b0, stat_det_pkg::IX_IRQ_STAT, 8'h00);
      `CHK(rd_v[0], 1'b1)
      idle(2);
      `CHK(irq, 1'b0)
      apb(1'b1, stat_det_pkg::IX_WAKE_THS, 8'h04);
      hp_a <= BIG;
      idle(2 * OUTPUT_DATA_RATE);
      hp_a <= 16'h0000;
      `CHK(n0, k + 1)
      apb(1'b1, stat_det_pkg::IX_WAKE_THS, 8'h01);
      apb(1'b1, stat_det_pkg::IX_OFS_CTRL, 8'h01);
      hp_a <= BIG;
      idle(3 * OUTPUT_DATA_RATE);
      hp_a <= 16'h0000;
      `CHK(n0, k + 1)
      ofs_a <= BIG;
      idle(3 * OUTPUT_DATA_RATE);
      ofs_a <= 16'h0000;
      idle(OUTPUT_DATA_RATE);
      `CHK(n0, k + 2)
      apb(1'b1, stat_det_pkg::IX_OFS_CTRL, 8'h00);
      apb(1'b1, stat_det_pkg::IX_WAKE_DURATION, 8'h60);
      hp_a <= BIG;
      idle(2 * OUTPUT_DATA_RATE);
      hp_a <= 16'h0000;
      idle(2 * OUTPUT_DATA_RATE);
      `CHK(n0, k + 2)
      hp_a <= BIG;
      idle(5 * OUTPUT_DATA_RATE);
      hp_a <= 16'h0000;
      idle(2 * OUTPUT_DATA_RATE);
      `CHK(n0, k + 3)
      `CHK(w0, OUTPUT_DATA_RATE)
      apb(1'b1, stat_det_pkg::IX_WAKE_DURATION, 8'h00);
      apb(1'b1, stat_det_pkg::IX_INT_CTRL, 8'h04);
      hp_a <= BIG;
      idle(3 * OUTPUT_DATA_RATE);
      hp_a <= 16'h0000;
      idle(OUTPUT_DATA_RATE);
      `CHK(int0_pin, 1'b1)
      apb(1'b0, stat_det_pkg::IX_INT_SRC, 8'h00);
      `CHK(rd_v[0], 1'b1)
      idle(2);
      `CHK(int0_pin, 1'b0)
      $display("test wake done");
   endtask : t_wake

   task automatic t_sleep();
      apb(1'b1, stat_det_pkg::IX_ROUTE, 8'h02);
      apb(1'b1, stat_det_pkg::IX_WAKE_THS, 8'h01);
      apb(1'b1, stat_det_pkg::IX_WAKE_DURATION, 8'h11);
      hp_b <= 16'hFF00;
      idle(8 * OUTPUT_DATA_RATE);
      `CHK(int1_pin, 1'b0)
      apb(1'b1, stat_det_pkg::IX_WAKE_THS, 8'h41);
      for (int j = 0; j < 8 * OUTPUT_DATA_RATE && int1_pin !== 1'b1; j++)
         @(posedge pclk);
      `CHK(int1_pin, 1'b1)
      `CHK(stat, 1'b1)
      apb(1'b0, stat_det_pkg::IX_INT_SRC, 8'h00);
      `CHK(rd_v[1], 1'b1)
      apb(1'b1, stat_det_pkg::IX_INT_CTRL, 8'h00);
      apb(1'b1, stat_det_pkg::IX_ROUTE, 8'h05);
      idle(CHG + 10);
      `CHK(int1_pin, 1'b0)
      hp_a <= BIG;
      idle(2 * OUTPUT_DATA_RATE + CHG);
      hp_a <= 16'h0000;
      `CHK(w1, CHG)
      `CHK(w0, OUTPUT_DATA_RATE)
      `CHK(stat, 1'b0)
      apb(1'b0, stat_det_pkg::IX_INT_SRC, 8'h00);
      `CHK(rd_v[1], 1'b0)
      $display("test sleep done");
   endtask : t_sleep

   initial
   begin
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      t_reset();
      t_wake();
      t_sleep();
      report_and_stop();
   end
endmodule : stationary_activity_detector_bench
